/* File: design/sac_sequencer.sv */
// Control and result logic of a 10-bit successive-approximation converter.
// Assumes a single 100 MHz clock, an Avalon-MM master, and an analog front end
// whose comparator output is asynchronous to the clock.
//
// What this block does
// - High result register shows result bits 9..2, bit 9 on top.
// - Low register holds bits 1..0 in 7..6, done in 5, busy in 4.
// - Done flag reads zero before and during a triggered conversion, one after completion; repeat restarts keep it set.
// - Busy rises at conversion start, falls at finish except in repeat mode, forced low by STOP.
// - Reading the high result clears done; software reads low first.
// - Low register bits 3..0 are undefined; this design returns zero.
// - Software mode: writing the trigger starts one conversion of the selected channel.
// - On completion store result, set done and raise the interrupt together.
// - The trigger bit clears itself once the conversion has begun.
// - Repeat mode: trigger starts conversions, each completion starts the next.
// - Writing disable mode stops conversion at once, partial result discarded.
// - Result appears only after the selected conversion time from start.
// - A triggered start clears done but keeps the old result until completion.
// - STOP aborts conversion, resets both control registers, loses the result.
// - After STOP nothing restarts by itself; software reprograms and retriggers.
// - During STOP the reference ladder is disconnected.
// - Software mode starts on the trigger write once idle and past the lockout; no external event qualifies it.
// - Control one: trigger bit 7, mode 6..5, input disable 4, channel 3..0.
// - Time codes 000,010..110 give 39,78,156,312,624,1248 clocks; 001,111 reserved.
// - After control one is written zero, no start for four cycles.
// - Ladder option clear: connected only while converting; set: connected except during STOP.
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`include "sac_defs.svh"

module sac_sequencer
	import sac_pkg::*;
(
	// Clock and reset.
	input  wire logic        CORE_CLK,
	input  wire logic        SYS_RST,
	// Avalon-MM register slave, word addressed.
	input  wire logic [7:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	// System and analog front end.
	input  wire logic        STANDBY_STOP,
	input  wire logic        COMP_IN,
	output logic      [9:0]  DAC_CODE,
	output logic             SAMPLE_HOLD,
	output logic             LADDER_ON,
	output logic      [3:0]  CHANNEL_SEL,
	output logic             INPUT_DISABLE,
	// Interrupt request toward the interrupt controller.
	output logic             CONV_DONE_IRQ
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	sac_state_t  state_r;
	sac_ctl1_t   ctl1_r;
	sac_ctl2_t   ctl2_r;
	logic [9:0]  result_r;
	logic [9:0]  work_r;
	logic [9:0]  work_nxt;
	logic [3:0]  bit_idx_r;
	logic [11:0] acc_r;
	logic [10:0] tconv_r;
	logic [10:0] cyc_r;
	logic [2:0]  lock_r;
	logic        done_r;
	logic        irq_r;
	logic        sample_r;
	logic        rd_pend_r;
	logic [31:0] rdata_r;
	logic        comp_m_r;
	logic        comp_s_r;
	logic        busy;
	logic        wr_ok;
	logic        rd_ok;
	logic        wr_c1;
	logic        start_go;
	logic        decide;
	logic        conv_end;
	logic        abort;

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------

	// Reads wait one cycle so that read data come from a flip-flop; writes finish at once.
	assign AVS_WAITREQUEST = AVS_READ & ~rd_pend_r;
	assign rd_ok = AVS_READ & rd_pend_r;
	assign wr_ok = AVS_WRITE & AVS_BYTEENABLE[0];
	assign wr_c1 = wr_ok & (AVS_ADDRESS == `SAC_IDX_CTL_ONE) & ~STANDBY_STOP;
	assign AVS_READDATA = rdata_r;

	// Read pending toggles so each read ends after exactly one wait cycle.
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST)
			rd_pend_r <= 1'b0;
		else
			rd_pend_r <= AVS_READ & ~rd_pend_r;
	end

	// Read data mux; unmapped addresses read as zero.
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			rdata_r <= 32'h0000_0000;
		end else if (AVS_READ & ~rd_pend_r) begin
			case (AVS_ADDRESS)
				`SAC_IDX_CTL_ONE:  rdata_r <= {24'h00_0000, ctl1_r};
				`SAC_IDX_CTL_TWO:  rdata_r <= {26'h000_0000, ctl2_r.ladder, 1'b1, ctl2_r.ack, 1'b0};
				`SAC_IDX_RES_LOW:  rdata_r <= {24'h00_0000, result_r[1:0], done_r, busy, 4'h0};
				`SAC_IDX_RES_HIGH: rdata_r <= {24'h00_0000, result_r[9:2]};
				default:           rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------

	// Control one; STOP holds it at its reset value and blocks writes.
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST || STANDBY_STOP) begin
			ctl1_r <= `SAC_RST_CTL_ONE;
		end else begin
			if (wr_c1) begin
				ctl1_r.mode   <= sac_mode_t'(AVS_WRITEDATA[6:5]);
				ctl1_r.in_dis <= AVS_WRITEDATA[4];
				ctl1_r.chan   <= AVS_WRITEDATA[3:0];
			end
			// The trigger only sets on write; it drops when the conversion begins.
			if (start_go)
				ctl1_r.trig <= 1'b0;
			else if (wr_c1 && AVS_WRITEDATA[`SAC_CTL1_TRIG_BIT])
				ctl1_r.trig <= 1'b1;
		end
	end

	// Control two holds the ladder option and the time code.
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST || STANDBY_STOP)
			ctl2_r <= `SAC_RST_CTL_TWO;
		else if (wr_ok && AVS_ADDRESS == `SAC_IDX_CTL_TWO)
			ctl2_r <= {AVS_WRITEDATA[`SAC_CTL2_LADDER_BIT], AVS_WRITEDATA[3:1]};
	end

	// Start lockout after control one is cleared; the mode decode settles in that time.
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST)
			lock_r <= 3'd0;
		else if (wr_c1 && AVS_WRITEDATA[7:0] == 8'h00)
			lock_r <= `SAC_LOCK_CYC;
		else if (lock_r != 3'd0)
			lock_r <= lock_r - 3'd1;
	end

	// ------------------------------------------------------------
	// Sequencing
	// ------------------------------------------------------------

	// Conversion time per code; reserved codes fall back to the longest time.
	function automatic logic [10:0] conv_time(input logic [2:0] code);
		case (code)
			3'b000:  conv_time = `SAC_CT_39;
			3'b010:  conv_time = `SAC_CT_78;
			3'b011:  conv_time = `SAC_CT_156;
			3'b100:  conv_time = `SAC_CT_312;
			3'b101:  conv_time = `SAC_CT_624;
			default: conv_time = `SAC_CT_1248;
		endcase
	endfunction

	assign busy = (state_r == SAC_ST_CONV);
	// A start needs the trigger in a converting mode while idle, outside the lockout and STOP; no further event qualifies it.
	assign start_go = ~STANDBY_STOP & ~busy & ctl1_r.trig & (lock_r == 3'd0) &
		(ctl1_r.mode == SAC_MD_SW || ctl1_r.mode == SAC_MD_REP);
	// Phase accumulator: ten decisions fall evenly over the selected time.
	// The sum stays below 1258, so twelve bits cannot overflow here.
	assign decide = busy & ((acc_r + `SAC_NBITS) >= {1'b0, tconv_r});
	assign abort = STANDBY_STOP | (wr_c1 & (AVS_WRITEDATA[6:5] == SAC_MD_OFF));
	assign conv_end = decide & (bit_idx_r == 4'd0) & ~abort;

	// Main state machine.
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			state_r <= SAC_ST_IDLE;
		end else begin
			case (state_r)
				SAC_ST_IDLE:
					if (start_go)
						state_r <= SAC_ST_CONV;
				SAC_ST_CONV:
					if (abort)
						state_r <= SAC_ST_IDLE;
					else if (conv_end && ctl1_r.mode != SAC_MD_REP)
						state_r <= SAC_ST_IDLE;
				default:
					state_r <= SAC_ST_IDLE;
			endcase
		end
	end

	// Timing: the accumulator, the latched time and a cycle count since start.
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			acc_r   <= 12'd0;
			tconv_r <= `SAC_CT_1248;
			cyc_r   <= 11'd0;
		end else if (start_go || (conv_end && ctl1_r.mode == SAC_MD_REP)) begin
			acc_r   <= 12'd0;
			tconv_r <= conv_time(ctl2_r.ack);
			cyc_r   <= 11'd0;
		end else if (busy) begin
			acc_r <= decide ? acc_r + `SAC_NBITS - {1'b0, tconv_r} : acc_r + `SAC_NBITS;
			cyc_r <= cyc_r + 11'd1;
		end
	end

	// Comparator synchroniser; only the second stage is read.
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			comp_m_r <= 1'b0;
			comp_s_r <= 1'b0;
		end else begin
			comp_m_r <= COMP_IN;
			comp_s_r <= comp_m_r;
		end
	end

	// Trial bit resolution: keep the bit if input is at or above the trial, then try the next.
	always_comb begin
		work_nxt = work_r;
		if (!comp_s_r)
			work_nxt[bit_idx_r] = 1'b0;
		if (bit_idx_r != 4'd0)
			work_nxt[bit_idx_r - 4'd1] = 1'b1;
	end

	// Successive approximation register, MSB first.
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			work_r    <= 10'h000;
			bit_idx_r <= 4'd0;
		end else if (start_go || (conv_end && ctl1_r.mode == SAC_MD_REP)) begin
			work_r    <= 10'h200;
			bit_idx_r <= 4'd9;
		end else if (decide) begin
			work_r    <= work_nxt;
			bit_idx_r <= (bit_idx_r == 4'd0) ? 4'd0 : bit_idx_r - 4'd1;
		end
	end

	// ------------------------------------------------------------
	// Results and flags
	// ------------------------------------------------------------

	// Result register; an aborted conversion never reaches it, STOP clears it.
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST || STANDBY_STOP)
			result_r <= `SAC_RST_RES;
		else if (conv_end)
			result_r <= work_nxt;
	end

	// Done flag; completion wins over a clearing high read in the same cycle.
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST || STANDBY_STOP)
			done_r <= 1'b0;
		else if (conv_end)
			done_r <= 1'b1;
		else if (start_go)
			done_r <= 1'b0;
		else if (rd_ok && AVS_ADDRESS == `SAC_IDX_RES_HIGH)
			done_r <= 1'b0;
	end

	// Interrupt and sample pulses, one cycle each.
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			irq_r    <= 1'b0;
			sample_r <= 1'b0;
		end else begin
			irq_r    <= conv_end;
			sample_r <= start_go | (conv_end & (ctl1_r.mode == SAC_MD_REP));
		end
	end

	// Front end outputs.
	assign CONV_DONE_IRQ = irq_r;
	assign SAMPLE_HOLD   = sample_r;
	assign DAC_CODE      = work_r;
	assign CHANNEL_SEL   = ctl1_r.chan;
	assign INPUT_DISABLE = ctl1_r.in_dis;
	// Ladder follows the option, but STOP always opens it to stop reference current.
	assign LADDER_ON = ~STANDBY_STOP & (ctl2_r.ladder | busy);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_begin;
		start_go;
	endsequence
	sequence s_finish;
		irq_r && done_r;
	endsequence

	property p_busy_start;
		@(posedge CORE_CLK) disable iff (SYS_RST) s_begin |=> busy && !ctl1_r.trig && !done_r;
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("Start did not raise busy.");

	property p_done_irq;
		@(posedge CORE_CLK) disable iff (SYS_RST) conv_end |=> s_finish ##1 !irq_r;
	endproperty
	a_done_irq: assert property (p_done_irq) else $error("Completion flags wrong.");

	property p_trig_clear;
		@(posedge CORE_CLK) disable iff (SYS_RST) s_begin |=> !ctl1_r.trig;
	endproperty
	a_trig_clear: assert property (p_trig_clear) else $error("Trigger not cleared.");

	property p_time;
		@(posedge CORE_CLK) disable iff (SYS_RST) conv_end |-> cyc_r == tconv_r - 11'd1;
	endproperty
	a_time: assert property (p_time) else $error("Conversion time wrong.");

	property p_abort;
		@(posedge CORE_CLK) disable iff (SYS_RST)
			busy && wr_c1 && AVS_WRITEDATA[6:5] == 2'b00 |=> !busy && $stable(result_r) && !irq_r;
	endproperty
	a_abort: assert property (p_abort) else $error("Disable did not stop cleanly.");

	property p_stop;
		@(posedge CORE_CLK) disable iff (SYS_RST)
			STANDBY_STOP |=> !busy && ctl1_r == `SAC_RST_CTL_ONE && ctl2_r == `SAC_RST_CTL_TWO;
	endproperty
	a_stop: assert property (p_stop) else $error("STOP did not initialise.");

	property p_ladder;
		@(posedge CORE_CLK) disable iff (SYS_RST) STANDBY_STOP |-> !LADDER_ON;
	endproperty
	a_ladder: assert property (p_ladder) else $error("Ladder on in STOP.");

	property p_lock;
		@(posedge CORE_CLK) disable iff (SYS_RST)
			wr_c1 && AVS_WRITEDATA[7:0] == 8'h00 |=> !start_go [*4];
	endproperty
	a_lock: assert property (p_lock) else $error("Start within lockout.");

	property p_hi_read;
		@(posedge CORE_CLK) disable iff (SYS_RST)
			rd_ok && AVS_ADDRESS == `SAC_IDX_RES_HIGH && !conv_end |=> !done_r;
	endproperty
	a_hi_read: assert property (p_hi_read) else $error("High read kept done.");

	property p_repeat;
		@(posedge CORE_CLK) disable iff (SYS_RST)
			conv_end && ctl1_r.mode == SAC_MD_REP && !STANDBY_STOP |=> busy && cyc_r == 11'd0;
	endproperty
	a_repeat: assert property (p_repeat) else $error("Repeat did not restart.");

	property p_restart;
		@(posedge CORE_CLK) disable iff (SYS_RST) s_begin |=> !done_r && $stable(result_r);
	endproperty
	a_restart: assert property (p_restart) else $error("Start disturbed the old result.");

endmodule : sac_sequencer

/* File: design/sac_defs.svh */
// Register offsets, field positions, reset values and timing counts of the converter sequencer.
// Included by the design; holds definitions only.
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH
// Register indexes; the bus byte address is four times the index.
`define SAC_IDX_CTL_ONE     8'h26
`define SAC_IDX_CTL_TWO     8'h27
`define SAC_IDX_RES_LOW     8'h28
`define SAC_IDX_RES_HIGH    8'h29
// Reset values.
`define SAC_RST_CTL_ONE     8'h10
`define SAC_RST_CTL_TWO     4'h0
`define SAC_RST_RES         10'h000
// Field positions.
`define SAC_CTL1_TRIG_BIT   7
`define SAC_LOW_DONE_BIT    5
`define SAC_LOW_BUSY_BIT    4
`define SAC_CTL2_LADDER_BIT 5
`define SAC_CTL2_FIXED_BIT  4
// Conversion times in system clock periods.
`define SAC_CT_39           11'd39
`define SAC_CT_78           11'd78
`define SAC_CT_156          11'd156
`define SAC_CT_312          11'd312
`define SAC_CT_624          11'd624
`define SAC_CT_1248         11'd1248
// Decisions per conversion and start lockout after clearing control one.
`define SAC_NBITS           12'd10
`define SAC_LOCK_CYC        3'd4
`endif

/* File: design/sac_pkg.sv */
// Types shared by the converter sequencer.
// Assumes sac_defs.svh is on the include path.
package sac_pkg;
	typedef enum logic [1:0] {
		SAC_MD_OFF = 2'b00,
		SAC_MD_SW  = 2'b01,
		SAC_MD_RSV = 2'b10,
		SAC_MD_REP = 2'b11
	} sac_mode_t;

	typedef enum logic [1:0] {
		SAC_ST_IDLE = 2'b01,
		SAC_ST_CONV = 2'b10
	} sac_state_t;

	typedef struct packed {
		logic      trig;
		sac_mode_t mode;
		logic      in_dis;
		logic [3:0] chan;
	} sac_ctl1_t;

	typedef struct packed {
		logic       ladder;
		logic [2:0] ack;
	} sac_ctl2_t;
endpackage : sac_pkg

/* File: bench/sac_comp_model.sv */
// Behavioural analog front end: sample-hold stage and comparator.
// Assumes the sequencer pulses sample_hold once at each conversion start.
`timescale 1ns/1ps

module sac_comp_model (
	// Sequencer side.
	input  wire logic       clk,
	input  wire logic       sample_hold,
	input  wire logic [9:0] dac_code,
	// Analog level and decision.
	input  wire logic [9:0] vin,
	output logic            comp_out
);
	logic [9:0] held_r = 10'h000;

	// Capture at the start pulse, so later input changes cannot disturb a running conversion.
	always @(posedge clk) begin
		if (sample_hold)
			held_r <= vin;
	end

	// Transparent during the pulse; one while the held level reaches the trial code.
	assign comp_out = ((sample_hold ? vin : held_r) >= dac_code);
endmodule : sac_comp_model

/* File: bench/sar_adc_sequencer_tb.sv */
// Self-checking bench of the converter sequencer, with a comparator model.
// Assumes the register index map and the bus timing of the sequencer.
`timescale 1ns/1ps

module sar_adc_sequencer_tb;
	import sac_pkg::*;
	logic clk, rst, avs_read, avs_write, stop, avs_waitrequest, sample_hold, ladder_on, in_dis, irq, comp_in;
	logic [7:0] avs_address, v;
	logic [31:0] avs_writedata, avs_readdata;
	logic [9:0] dac_code, vin;
	logic [3:0] chan;
	int err_count, n_tests, cyc, irq_n, t0, tirq, c, r1, r2, m;
	int tt[8] = '{39, 1248, 78, 156, 312, 624, 1248, 1248};

	sac_sequencer i_dut (.CORE_CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
		.AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hf),
		.AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .STANDBY_STOP(stop),
		.COMP_IN(comp_in), .DAC_CODE(dac_code), .SAMPLE_HOLD(sample_hold), .LADDER_ON(ladder_on),
		.CHANNEL_SEL(chan), .INPUT_DISABLE(in_dis), .CONV_DONE_IRQ(irq));
	sac_comp_model i_comp (.clk(clk), .sample_hold(sample_hold), .dac_code(dac_code), .vin(vin),
		.comp_out(comp_in));

	// Clock, cycle stamp and interrupt tally.
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (irq === 1'b1)
			irq_n <= irq_n + 1;
	end

	task automatic conclude();
		$display("err_count=%0d n_tests=%0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude

	task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic hang();
		err_count++;
		$display("mismatch wait_bound expected answer seen none");
		conclude();
	endtask : hang

	// One bus cycle; request held until the rising edge at which waitrequest is seen low.
	// Values read right after the edge are those the slave sampled, since its updates are non-blocking.
	task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge clk);
		avs_read <= rd;
		avs_write <= !rd;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		if (n == 50)
			hang();
		v = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic wait_irq();
		int n;
		for (n = 0; n < 3000; n++) begin
			@(negedge clk);
			if (irq === 1'b1)
				break;
		end
		if (n == 3000)
			hang();
		tirq = cyc;
		@(negedge clk);
		chk("irq_pulse", 10'(irq), 10'h0);
	endtask : wait_irq

	// Result readout, low byte first; the high read clears the done flag.
	task automatic chk_res(input int r);
		bus(1, 8'h28, 8'h0);
		chk("res_low", 10'(v[7:6]), 10'(r[1:0]));
		chk("done_set", 10'(v[5]), 10'h1);
		bus(1, 8'h29, 8'h0);
		chk("res_high", 10'(v), 10'(r[9:2]));
		bus(1, 8'h28, 8'h0);
		chk("done_clr", 10'(v[5]), 10'h0);
	endtask : chk_res

	initial begin
		clk = 0; rst = 1; stop = 0; vin = 0; cyc = 0; irq_n = 0;
		avs_read = 0; avs_write = 0; avs_address = 0; avs_writedata = 0;
		void'($urandom(51));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		// ------------------------------------------------------------
		// Reset values and an unmapped place.
		// ------------------------------------------------------------
		bus(1, 8'h26, 8'h0);
		chk("ctl1_rst", 10'(v), 10'h10);
		chk("in_dis_rst", 10'(in_dis), 10'h1);
		bus(1, 8'h28, 8'h0);
		chk("low_rst", 10'(v[7:4]), 10'h0);
		bus(1, 8'h29, 8'h0);
		chk("high_rst", 10'(v), 10'h0);
		bus(1, 8'h30, 8'h0);
		chk("unmapped", 10'(v), 10'h0);
		// ------------------------------------------------------------
		// Software start for every time code, ladder option toggled.
		// ------------------------------------------------------------
		for (c = 0; c < 8; c++) begin
			r1 = $urandom_range(1023);
			vin <= 10'(r1);
			bus(0, 8'h27, 8'(8'h10 | (c[0] << 5) | (c << 1)));
			bus(0, 8'h26, 8'ha4);
			t0 = cyc;
			bus(1, 8'h28, 8'h0);
			chk("busy_run", 10'(v[5:4]), 10'h1);
			chk("ladder_run", 10'(ladder_on), 10'h1);
			chk("chan", 10'(chan), 10'h4);
			chk("in_dis", 10'(in_dis), 10'h0);
			bus(1, 8'h26, 8'h0);
			chk("ctl1_auto", 10'(v), 10'h24);
			wait_irq();
			chk("conv_time", 10'((tirq - t0 >= tt[c]) && (tirq - t0 <= tt[c] + 4)), 10'h1);
			chk_res(r1);
			chk("ladder_idle", 10'(ladder_on), 10'(c[0]));
		end
		// ------------------------------------------------------------
		// Restart before the high read keeps the old result.
		// ------------------------------------------------------------
		bus(0, 8'h27, 8'h10);
		bus(0, 8'h26, 8'ha4);
		wait_irq();
		r2 = $urandom_range(1023);
		vin <= 10'(r2);
		bus(0, 8'h26, 8'ha4);
		bus(1, 8'h28, 8'h0);
		chk("done_restart", 10'(v[5]), 10'h0);
		chk("low_kept", 10'(v[7:6]), 10'(r1[1:0]));
		bus(1, 8'h29, 8'h0);
		chk("high_kept", 10'(v), 10'(r1[9:2]));
		wait_irq();
		chk_res(r2);
		// ------------------------------------------------------------
		// Repeat mode, then stop by disable mode mid-conversion.
		// ------------------------------------------------------------
		r1 = $urandom_range(1023);
		vin <= 10'(r1);
		bus(0, 8'h26, 8'he4);
		wait_irq();
		chk_res(r1);
		r2 = $urandom_range(1023);
		vin <= 10'(r2);
		wait_irq();
		chk_res(r1);
		wait_irq();
		chk_res(r2);
		vin <= ~vin;
		bus(0, 8'h26, 8'h04);
		m = irq_n;
		bus(1, 8'h28, 8'h0);
		chk("busy_abort", 10'(v[4]), 10'h0);
		repeat (100) @(posedge clk);
		chk("irq_abort", 10'(irq_n - m), 10'h0);
		bus(1, 8'h29, 8'h0);
		chk("high_abort", 10'(v), 10'(r2[9:2]));
		// ------------------------------------------------------------
		// Trigger written inside the lockout after clearing control one stays pending.
		// ------------------------------------------------------------
		r1 = $urandom_range(1023);
		vin <= 10'(r1);
		bus(0, 8'h26, 8'h00);
		bus(0, 8'h26, 8'ha4);
		bus(1, 8'h26, 8'h0);
		chk("ctl1_lock", 10'(v), 10'ha4);
		wait_irq();
		chk_res(r1);
		// ------------------------------------------------------------
		// STOP standby in mid-conversion.
		// ------------------------------------------------------------
		bus(0, 8'h27, 8'h38);
		bus(1, 8'h27, 8'h0);
		chk("ctl2", 10'(v), 10'h38);
		bus(0, 8'h26, 8'ha4);
		repeat (20) @(posedge clk);
		stop <= 1'b1;
		@(negedge clk);
		chk("ladder_stop", 10'(ladder_on), 10'h0);
		bus(1, 8'h28, 8'h0);
		chk("busy_stop", 10'(v[4]), 10'h0);
		stop <= 1'b0;
		m = irq_n;
		bus(1, 8'h26, 8'h0);
		chk("ctl1_stop", 10'(v), 10'h10);
		bus(1, 8'h27, 8'h0);
		chk("ctl2_stop", 10'(v), 10'h10);
		repeat (1300) @(posedge clk);
		chk("no_resume", 10'(irq_n - m), 10'h0);
		chk("ladder_off", 10'(ladder_on), 10'h0);
		conclude();
	end
endmodule : sar_adc_sequencer_tb
